// file: hdl/gpx_io_port.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
`include "gpx_regs.svh"
module gpx_io_port
	import gpx_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Register port
	input wire gpx_bus_req_t bus_i,
	output logic [31:0] rdata_o,
	// Digital pins
	input wire logic [7:0] gen_in_i,
	input wire logic [39:0] ext_in_i,
	input wire logic [15:0] aux_enc_i,
	output logic [7:0] out_port_o,
	output logic [39:0] ext_out_o,
	output logic [39:0] ext_oe_o,
	// Converter
	output gpx_adc_req_t adc_o,
	input wire gpx_adc_rsp_t adc_i,
	// Program execution control
	input wire logic [15:0] pc_i,
	output logic isr_enter_o,
	output logic isr_active_o,
	output logic resume_o,
	output logic [15:0] resume_addr_o,
	output logic stall_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////////
	// Helper functions

	function automatic logic pick96(input logic [95:0] vec, input logic [7:0] n);
		pick96 = 1'b0;
		if (n >= 8'd1 && n <= 8'd96) begin
			pick96 = vec[7'(n - 8'd1)];
		end
	endfunction

	// Output number to flat index 0..47: 0..7 main port, 8..47 extra points
	function automatic logic [6:0] out_index(input logic [7:0] n);
		if (n >= 8'd1 && n <= 8'd8) begin
			out_index = 7'(n - 8'd1);
		end else if (n >= 8'd17 && n <= 8'd56) begin
			out_index = 7'(n - 8'd9);
		end else begin
			out_index = 7'h7f;
		end
	endfunction

	function automatic logic [39:0] grp_mask(input logic [4:0] dir);
		logic [39:0] m;
		m = 40'h00_0000_0000;
		for (int g = 0; g < 5; g++) begin
			m[g*8 +: 8] = {8{dir[g]}};
		end
		grp_mask = m;
	endfunction

	function automatic logic [15:0] to_mv(input logic [11:0] code);
		logic [31:0] p;
		p = {20'h0_0000, code} * `GPX_AN_SPAN_MV;
		to_mv = 16'(p[31:12]) - `GPX_AN_OFS_MV;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Decode

	logic wr_port, wr_set, wr_clr, wr_cond, wr_dir, wr_ext_lo, wr_ext_hi;
	logic wr_in_sel, wr_step, wr_an_sel, wr_rng, wr_mask, wr_ret, wr_stk_clr;
	logic wr_wait, wr_sclr, wr_sen;
	logic [7:0] cmd_num;
	logic [6:0] cmd_idx;
	logic cmd_ok;
	logic [4:0] dir_q;
	logic [47:0] outs;

	assign wr_port = bus_i.we && bus_i.addr == `GPX_OFS_OUT_PORT;
	assign wr_set = bus_i.we && bus_i.addr == `GPX_OFS_SET_BIT;
	assign wr_clr = bus_i.we && bus_i.addr == `GPX_OFS_CLR_BIT;
	assign wr_cond = bus_i.we && bus_i.addr == `GPX_OFS_COND_BIT;
	assign wr_dir = bus_i.we && bus_i.addr == `GPX_OFS_DIR_MASK;
	assign wr_ext_lo = bus_i.we && bus_i.addr == `GPX_OFS_EXT_LO;
	assign wr_ext_hi = bus_i.we && bus_i.addr == `GPX_OFS_EXT_HI;
	assign wr_in_sel = bus_i.we && bus_i.addr == `GPX_OFS_IN_SEL;
	assign wr_step = bus_i.we && bus_i.addr == `GPX_OFS_STEPPER;
	assign wr_an_sel = bus_i.we && bus_i.addr == `GPX_OFS_AN_SEL;
	assign wr_rng = bus_i.we && bus_i.addr == `GPX_OFS_IRQ_RANGE;
	assign wr_mask = bus_i.we && bus_i.addr == `GPX_OFS_IRQ_MASK;
	assign wr_ret = bus_i.we && bus_i.addr == `GPX_OFS_RET_IRQ;
	assign wr_stk_clr = bus_i.we && bus_i.addr == `GPX_OFS_STK_CLR;
	assign wr_wait = bus_i.we && bus_i.addr == `GPX_OFS_WAIT;
	assign wr_sclr = bus_i.we && bus_i.addr == `GPX_OFS_STS_CLR;
	assign wr_sen = bus_i.we && bus_i.addr == `GPX_OFS_STS_EN;

	assign cmd_num = bus_i.wdata[`GPX_FLD_NUM_MSB:0];
	assign cmd_idx = out_index(cmd_num);
	// Main port always writable; extra points only while their group is an output
	assign outs = {grp_mask(dir_q), 8'hff};
	assign cmd_ok = cmd_idx != 7'h7f && outs[6'(cmd_idx)];

	////////////////////////////////////////////////////////////////////////////////
	// Outputs and direction

	logic [7:0] out_q;
	logic [39:0] ext_q;
	logic [39:0] oe_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			dir_q <= `GPX_RST_DIR;
			oe_q <= `GPX_RST_EXT;
		end else if (wr_dir) begin
			dir_q <= bus_i.wdata[4:0];
			oe_q <= grp_mask(bus_i.wdata[4:0]);
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_q <= `GPX_RST_OUT;
			ext_q <= `GPX_RST_EXT;
		end else if (wr_port) begin
			out_q <= bus_i.wdata[7:0];
		end else if (wr_ext_lo) begin
			// Words for points set as inputs are ignored
			ext_q[31:0] <= (ext_q[31:0] & ~oe_q[31:0]) | (bus_i.wdata & oe_q[31:0]);
		end else if (wr_ext_hi) begin
			ext_q[39:32] <= (ext_q[39:32] & ~oe_q[39:32]) | (bus_i.wdata[7:0] & oe_q[39:32]);
		end else if ((wr_set || wr_clr || wr_cond) && cmd_ok) begin
			if (cmd_idx < 7'd8) begin
				out_q[3'(cmd_idx)] <= wr_set || (wr_cond && |bus_i.wdata[31:`GPX_FLD_OPND_LSB]);
			end else begin
				ext_q[6'(cmd_idx - 7'd8)] <= wr_set || (wr_cond && |bus_i.wdata[31:`GPX_FLD_OPND_LSB]);
			end
		end
	end

	assign out_port_o = out_q;
	assign ext_out_o = ext_q;
	assign ext_oe_o = oe_q;

	////////////////////////////////////////////////////////////////////////////////
	// Input space 1..96

	logic [7:0] step_q;
	logic [95:0] in_vec;
	logic [95:0] in_ok;

	always_comb begin
		in_vec = 96'h0;
		in_ok = 96'h0;
		in_vec[7:0] = gen_in_i;
		in_ok[7:0] = 8'hff;
		in_vec[55:16] = ext_in_i;
		in_ok[55:16] = {40{1'b1}};
		for (int a = 0; a < 8; a++) begin
			// Axis a: channel A is input 81+2a, channel B is 82+2a
			in_vec[80 + 2*a] = aux_enc_i[2*a] & ~step_q[a];
			in_vec[81 + 2*a] = aux_enc_i[2*a + 1] & ~step_q[a];
			in_ok[80 + 2*a] = ~step_q[a];
			in_ok[81 + 2*a] = ~step_q[a];
		end
	end

	logic [7:0] in_sel_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			in_sel_q <= 8'h01;
			step_q <= 8'h00;
		end else begin
			if (wr_in_sel) begin
				in_sel_q <= bus_i.wdata[7:0];
			end
			if (wr_step) begin
				step_q <= bus_i.wdata[7:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Analog sampler: scans all eight channels continuously

	gpx_adc_st_t ad_st_q;
	logic [2:0] ad_ch_q;
	logic [11:0] an_q [8];
	logic [2:0] an_sel_q;
	logic ad_start_q;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ad_st_q <= GPX_AD_ISSUE;
			ad_ch_q <= 3'h0;
			ad_start_q <= 1'b0;
		end else begin
			ad_start_q <= 1'b0;
			unique case (ad_st_q)
				GPX_AD_ISSUE: begin
					ad_start_q <= 1'b1;
					ad_st_q <= GPX_AD_WAIT;
				end
				GPX_AD_WAIT: begin
					if (adc_i.done) begin
						ad_st_q <= GPX_AD_NEXT;
					end
				end
				GPX_AD_NEXT: begin
					ad_ch_q <= ad_ch_q + 3'h1;
					ad_st_q <= GPX_AD_ISSUE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			for (int i = 0; i < 8; i++) begin
				an_q[i] <= 12'h000;
			end
			an_sel_q <= 3'h0;
		end else begin
			if (ad_st_q == GPX_AD_WAIT && adc_i.done) begin
				an_q[ad_ch_q] <= adc_i.data;
			end
			if (wr_an_sel) begin
				// Software index 1..8 selects channel 0..7
				an_sel_q <= 3'(bus_i.wdata[3:0] - 4'h1);
			end
		end
	end

	assign adc_o.start = ad_start_q;
	assign adc_o.chan = ad_ch_q;

	////////////////////////////////////////////////////////////////////////////////
	// Input interrupt and execution control

	logic [31:0] irq_en_q;
	logic pend;
	gpx_exec_st_t ex_q;
	logic stk_valid_q;
	logic [15:0] stk_q;
	logic enter_q, resume_q;
	logic [15:0] res_addr_q;

	// Only inputs 1..32 can be armed
	assign pend = |(irq_en_q & ~in_vec[31:0] & in_ok[31:0]);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			irq_en_q <= `GPX_RST_IRQ_EN;
		end else if (wr_mask) begin
			irq_en_q <= bus_i.wdata;
		end else if (wr_rng) begin
			for (int i = 0; i < 32; i++) begin
				irq_en_q[i] <= 8'(i + 1) >= bus_i.wdata[7:0] &&
					8'(i + 1) <= bus_i.wdata[`GPX_FLD_RNG_LAST_LSB +: 8];
			end
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ex_q <= GPX_EX_RUN;
			stk_valid_q <= 1'b0;
			stk_q <= 16'h0000;
			enter_q <= 1'b0;
			resume_q <= 1'b0;
			res_addr_q <= 16'h0000;
		end else begin
			enter_q <= 1'b0;
			resume_q <= 1'b0;
			unique case (ex_q)
				GPX_EX_RUN: begin
					if (pend) begin
						ex_q <= GPX_EX_ISR;
						stk_q <= pc_i;
						stk_valid_q <= 1'b1;
						enter_q <= 1'b1;
					end
				end
				GPX_EX_ISR: begin
					if (wr_ret) begin
						ex_q <= GPX_EX_RUN;
						stk_valid_q <= 1'b0;
						resume_q <= stk_valid_q;
						res_addr_q <= stk_q;
					end else if (wr_stk_clr) begin
						// Routine leaves by its own jump; nothing to resume
						ex_q <= GPX_EX_RUN;
						stk_valid_q <= 1'b0;
					end
				end
			endcase
		end
	end

	assign isr_enter_o = enter_q;
	assign isr_active_o = ex_q == GPX_EX_ISR;
	assign resume_o = resume_q;
	assign resume_addr_o = res_addr_q;

	////////////////////////////////////////////////////////////////////////////////
	// Wait for input level

	logic stall_q, wait_low_q, wait_hit;
	logic [7:0] wait_num_q;

	assign wait_hit = stall_q && (pick96(in_vec, wait_num_q) == ~wait_low_q);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			stall_q <= 1'b0;
			wait_low_q <= 1'b0;
			wait_num_q <= 8'h01;
		end else if (wr_wait && pick96(in_ok, bus_i.wdata[7:0])) begin
			stall_q <= 1'b1;
			wait_num_q <= bus_i.wdata[7:0];
			wait_low_q <= bus_i.wdata[`GPX_FLD_WAIT_LOW];
		end else if (wait_hit) begin
			stall_q <= 1'b0;
		end
	end

	assign stall_o = stall_q;

	////////////////////////////////////////////////////////////////////////////////
	// Status, enable and interrupt line

	logic [3:0] sts_q, sen_q, ev;
	logic irq_q;

	assign ev[`GPX_STS_ISR] = ex_q == GPX_EX_RUN && pend;
	assign ev[`GPX_STS_WAIT] = wait_hit;
	assign ev[`GPX_STS_BAD] = ((wr_set || wr_clr || wr_cond) && !cmd_ok) ||
		(wr_wait && !pick96(in_ok, bus_i.wdata[7:0]));
	assign ev[`GPX_STS_ADC] = ad_st_q == GPX_AD_WAIT && adc_i.done;

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			sts_q <= 4'h0;
			sen_q <= 4'h0;
			irq_q <= 1'b0;
		end else begin
			// A new event in the clear cycle survives
			sts_q <= (sts_q & ~(wr_sclr ? bus_i.wdata[3:0] : 4'h0)) | ev;
			if (wr_sen) begin
				sen_q <= bus_i.wdata[3:0];
			end
			irq_q <= |(sts_q & sen_q);
		end
	end

	assign irq_o = irq_q;

	////////////////////////////////////////////////////////////////////////////////
	// Read port

	logic [31:0] rd_q;
	logic [15:0] an_mv;

	assign an_mv = to_mv(an_q[an_sel_q]);

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rd_q <= 32'h0000_0000;
		end else if (bus_i.re) begin
			unique case (bus_i.addr)
				`GPX_OFS_OUT_PORT: rd_q <= {24'h00_0000, out_q};
				`GPX_OFS_DIR_MASK: rd_q <= {27'h000_0000, dir_q};
				`GPX_OFS_EXT_LO: rd_q <= ext_q[31:0];
				`GPX_OFS_EXT_HI: rd_q <= {24'h00_0000, ext_q[39:32]};
				`GPX_OFS_IN_SEL: rd_q <= {24'h00_0000, in_sel_q};
				`GPX_OFS_IN_LEVEL: rd_q <= {30'h0000_0000, pick96(in_ok, in_sel_q), pick96(in_vec, in_sel_q)};
				`GPX_OFS_STEPPER: rd_q <= {24'h00_0000, step_q};
				`GPX_OFS_AN_SEL: rd_q <= {28'h000_0000, 4'({1'b0, an_sel_q} + 4'h1)};
				`GPX_OFS_AN_VAL: rd_q <= {{16{an_mv[15]}}, an_mv};
				`GPX_OFS_IRQ_MASK: rd_q <= irq_en_q;
				`GPX_OFS_WAIT: rd_q <= {23'h00_0000, wait_low_q, wait_num_q};
				`GPX_OFS_EXEC: rd_q <= {stk_q, 13'h0000, stall_q, stk_valid_q, ex_q == GPX_EX_ISR};
				`GPX_OFS_STATUS: rd_q <= {28'h000_0000, sts_q};
				`GPX_OFS_STS_EN: rd_q <= {28'h000_0000, sen_q};
				default: rd_q <= 32'h0000_0000;
			endcase
		end else begin
			rd_q <= 32'h0000_0000;
		end
	end

	assign rdata_o = rd_q;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking dflt_clk @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	logic [2:0] a_bit;
	assign a_bit = 3'(cmd_num - 8'd1);

	chk_set_bit_high: assert property (
		wr_set && cmd_num >= 8'd1 && cmd_num <= 8'd8 |=> out_port_o[$past(a_bit)] &&
		(out_port_o & ~(8'h01 << $past(a_bit))) == ($past(out_port_o) & ~(8'h01 << $past(a_bit))))
		else $error("set bit did not drive one output high");
	chk_clr_bit_low: assert property (
		wr_clr && cmd_num >= 8'd1 && cmd_num <= 8'd8 |=> !out_port_o[$past(a_bit)])
		else $error("clear bit did not drive output low");
	chk_cond_bit_value: assert property (
		wr_cond && cmd_num >= 8'd1 && cmd_num <= 8'd8 |=>
		out_port_o[$past(a_bit)] == $past(|bus_i.wdata[31:8]))
		else $error("conditional write wrong level");
	chk_word_load_all: assert property (
		wr_port |=> out_port_o == $past(bus_i.wdata[7:0]))
		else $error("port word not loaded");
	chk_level_query: assert property (
		bus_i.re && bus_i.addr == `GPX_OFS_IN_LEVEL && in_sel_q == 8'd81 && !step_q[0] |=>
		rdata_o[1:0] == {1'b1, $past(aux_enc_i[0])})
		else $error("input 81 query wrong");
	chk_stepper_hide: assert property (
		step_q[0] |-> !in_ok[80] && !in_ok[81] && !in_vec[80])
		else $error("stepper axis aux input offered");
	chk_isr_entry: assert property (
		ex_q == GPX_EX_RUN && pend |=> isr_enter_o && isr_active_o ##1 !isr_enter_o)
		else $error("interrupt branch not taken");
	chk_resume_point: assert property (
		ex_q == GPX_EX_ISR && wr_ret && stk_valid_q |=> resume_o && resume_addr_o == $past(stk_q))
		else $error("return point lost");
	chk_stack_drop: assert property (
		ex_q == GPX_EX_ISR && wr_stk_clr && !wr_ret |=> !stk_valid_q && !resume_o)
		else $error("stack clear kept return point");
	chk_wait_release: assert property (
		stall_q && !wr_wait && pick96(in_vec, wait_num_q) == ~wait_low_q |=> !stall_o)
		else $error("wait not released");
	chk_dir_gate: assert property (
		wr_ext_lo && !dir_q[0] |=> ext_out_o[7:0] == $past(ext_out_o[7:0]))
		else $error("input group written");
	chk_mask_load: assert property (
		wr_mask |=> irq_en_q == $past(bus_i.wdata))
		else $error("interrupt mask not loaded");

	cov_isr_round: cover property (isr_enter_o ##[1:50] resume_o);
	cov_wait_low: cover property (stall_q && wait_low_q ##1 !stall_q);
	cov_irq_line: cover property ($rose(irq_o));

endmodule // gpx_io_port

// file: hdl/gpx_regs.svh
`ifndef GPX_REGS_SVH
`define GPX_REGS_SVH

// Register byte offsets
`define GPX_OFS_OUT_PORT 8'h00
`define GPX_OFS_SET_BIT 8'h04
`define GPX_OFS_CLR_BIT 8'h08
`define GPX_OFS_COND_BIT 8'h0c
`define GPX_OFS_DIR_MASK 8'h10
`define GPX_OFS_EXT_LO 8'h14
`define GPX_OFS_EXT_HI 8'h18
`define GPX_OFS_IN_SEL 8'h1c
`define GPX_OFS_IN_LEVEL 8'h20
`define GPX_OFS_STEPPER 8'h24
`define GPX_OFS_AN_SEL 8'h28
`define GPX_OFS_AN_VAL 8'h2c
`define GPX_OFS_IRQ_RANGE 8'h30
`define GPX_OFS_IRQ_MASK 8'h34
`define GPX_OFS_RET_IRQ 8'h38
`define GPX_OFS_STK_CLR 8'h3c
`define GPX_OFS_WAIT 8'h40
`define GPX_OFS_EXEC 8'h44
`define GPX_OFS_STATUS 8'h48
`define GPX_OFS_STS_CLR 8'h4c
`define GPX_OFS_STS_EN 8'h50

// Field positions
`define GPX_FLD_NUM_MSB 7
`define GPX_FLD_OPND_LSB 8
`define GPX_FLD_WAIT_LOW 8
`define GPX_FLD_RNG_LAST_LSB 8
`define GPX_STS_ISR 0
`define GPX_STS_WAIT 1
`define GPX_STS_BAD 2
`define GPX_STS_ADC 3

// Reset values
`define GPX_RST_OUT 8'h00
`define GPX_RST_EXT 40'h00_0000_0000
`define GPX_RST_DIR 5'h00
`define GPX_RST_IRQ_EN 32'h0000_0000

// Analog scaling: full scale span and offset in millivolts
`define GPX_AN_SPAN_MV 32'd20000
`define GPX_AN_OFS_MV 16'd10000

`endif

// file: hdl/gpx_pkg.sv
package gpx_pkg;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic we;
		logic re;
	} gpx_bus_req_t;

	typedef struct packed {
		logic start;
		logic [2:0] chan;
	} gpx_adc_req_t;

	typedef struct packed {
		logic done;
		logic [11:0] data;
	} gpx_adc_rsp_t;

	typedef enum logic {
		GPX_EX_RUN,
		GPX_EX_ISR
	} gpx_exec_st_t;

	typedef enum logic [1:0] {
		GPX_AD_ISSUE,
		GPX_AD_WAIT,
		GPX_AD_NEXT
	} gpx_adc_st_t;

endpackage

// file: sim/gpx_pins_model.sv
`timescale 1ns/100ps
module gpx_pins_model
	import gpx_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Levels requested by the bench
	input wire logic [7:0] gen_lvl_i,
	input wire logic [39:0] ext_lvl_i,
	input wire logic [15:0] aux_lvl_i,
	input wire logic slow_i,
	// Pin side of the port
	input wire logic [39:0] ext_out_i,
	input wire logic [39:0] ext_oe_i,
	output logic [7:0] gen_in_o,
	output logic [39:0] ext_in_o,
	output logic [15:0] aux_enc_o,
	// Converter side
	input wire gpx_adc_req_t adc_i,
	output gpx_adc_rsp_t adc_o
);
	logic [3:0] cnt_q;
	logic busy_q;
	logic [2:0] chan_q;

	assign gen_in_o = gen_lvl_i;
	assign aux_enc_o = aux_lvl_i;
	// A driven point reads back what the port itself drives on it
	assign ext_in_o = (ext_oe_i & ext_out_i) | (~ext_oe_i & ext_lvl_i);

	////////////////////////////////////////////////////////////////
	// Converter: code (2c+1)*256 per channel, so millivolts come out exact
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			chan_q <= 3'h0;
			adc_o <= '0;
		end else begin
			adc_o.done <= 1'b0;
			// Data outside the done cycle is inverted each cycle, so the last result returns every other cycle
			adc_o.data <= ~adc_o.data;
			if (adc_i.start) begin
				busy_q <= 1'b1;
				chan_q <= adc_i.chan;
				cnt_q <= slow_i ? 4'h9 : 4'h1;
			end else if (busy_q) begin
				if (cnt_q == 4'h0) begin
					busy_q <= 1'b0;
					adc_o.done <= 1'b1;
					adc_o.data <= {chan_q, 9'h100};
				end else begin
					cnt_q <= cnt_q - 4'h1;
				end
			end
		end
	end
endmodule // gpx_pins_model

// file: sim/testbench.sv
`timescale 1ns/100ps
`include "gpx_regs.svh"
module testbench
	import gpx_pkg::*;
;
	logic clk_i, sys_rst_i, slow;
	gpx_bus_req_t bus;
	logic [31:0] rdata, v, e;
	logic [7:0] gen_in, gen_lvl, out_port, b8;
	logic [39:0] ext_in, ext_lvl, ext_out, ext_oe;
	logic [15:0] aux_enc, aux_lvl, pc, resume_addr;
	gpx_adc_req_t adc_req;
	gpx_adc_rsp_t adc_rsp;
	logic isr_enter, isr_active, resume, stall, irq;
	int n_fail, checks_done;
	int nums[7] = '{9, 25, 24, 81, 82, 96, 17};
	logic [31:0] exps[7] = '{32'h0, 32'h3, 32'h2, 32'h2, 32'h3, 32'h2, 32'h2};

	gpx_io_port gpx_io_port_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus_i(bus), .rdata_o(rdata),
		.gen_in_i(gen_in), .ext_in_i(ext_in), .aux_enc_i(aux_enc), .out_port_o(out_port),
		.ext_out_o(ext_out), .ext_oe_o(ext_oe), .adc_o(adc_req), .adc_i(adc_rsp), .pc_i(pc),
		.isr_enter_o(isr_enter), .isr_active_o(isr_active), .resume_o(resume),
		.resume_addr_o(resume_addr), .stall_o(stall), .irq_o(irq));

	gpx_pins_model gpx_pins_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .gen_lvl_i(gen_lvl),
		.ext_lvl_i(ext_lvl), .aux_lvl_i(aux_lvl), .slow_i(slow), .ext_out_i(ext_out), .ext_oe_i(ext_oe),
		.gen_in_o(gen_in), .ext_in_o(ext_in), .aux_enc_o(aux_enc), .adc_i(adc_req), .adc_o(adc_rsp));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("comparisons %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// Writes end one step past the taking edge so their effect has landed
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.wdata <= d;
		bus.we <= 1'b1;
		@(posedge clk_i);
		bus.we <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		bus.addr <= a;
		bus.re <= 1'b1;
		@(posedge clk_i);
		bus.re <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		rd(a, v);
		chk(v, exp);
	endtask

	function automatic logic sig(input int s);
		case (s)
			0: return isr_enter;
			1: return isr_active;
			2: return resume;
			3: return stall;
			default: return irq;
		endcase
	endfunction

	task automatic wait_for(input int s, input logic val);
		for (int i = 0; i < 40; i++) begin
			if (sig(s) === val) return;
			@(posedge clk_i);
			#1;
		end
		chk(sig(s), val);
		finish_test();
	endtask

	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		finish_test();
	end

	////////////////////////////////////////////////////////////////
	initial begin
		sys_rst_i = 1'b1;
		bus = '0;
		gen_lvl = 8'hff;
		ext_lvl = 40'h00_0000_0000;
		aux_lvl = 16'h0000;
		pc = 16'h1234;
		slow = 1'b0;
		n_fail = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk(out_port, 8'h00);
		chk(ext_oe, 40'h00_0000_0000);
		rchk(`GPX_OFS_DIR_MASK, 32'h0);
		rchk(`GPX_OFS_IRQ_MASK, 32'h0);
		wr(`GPX_OFS_OUT_PORT, 32'h6);
		chk(out_port, 8'h06);
		wr(`GPX_OFS_OUT_PORT, 32'hff);
		rchk(`GPX_OFS_OUT_PORT, 32'hff);
		wr(`GPX_OFS_OUT_PORT, 32'h0);
		chk(out_port, 8'h00);
		for (int n = 1; n <= 8; n++) begin
			wr(`GPX_OFS_SET_BIT, n);
			b8 = 8'((9'h1 << n) - 9'h1);
			chk(out_port, b8);
		end
		for (int n = 1; n <= 8; n++) begin
			wr(`GPX_OFS_CLR_BIT, n);
			b8 = 8'hff << n;
			chk(out_port, b8);
		end
		wr(`GPX_OFS_COND_BIT, 32'h0000_0103);
		wr(`GPX_OFS_COND_BIT, 32'h8000_0008);
		chk(out_port, 8'h84);
		wr(`GPX_OFS_COND_BIT, 32'h0000_0003);
		rchk(`GPX_OFS_OUT_PORT, 32'h80);
		// Extra points: groups one and three driven
		wr(`GPX_OFS_DIR_MASK, 32'h05);
		chk(ext_oe, 40'h00_00ff_00ff);
		wr(`GPX_OFS_EXT_LO, 32'hffff_ffff);
		chk(ext_out & ext_oe, 40'h00_00ff_00ff);
		wr(`GPX_OFS_CLR_BIT, 17);
		chk(ext_out & ext_oe, 40'h00_00ff_00fe);
		wr(`GPX_OFS_SET_BIT, 49);
		chk(ext_out & ext_oe, 40'h00_00ff_00fe);
		rd(`GPX_OFS_STATUS, v);
		chk(v[`GPX_STS_BAD], 1'b1);
		wr(`GPX_OFS_DIR_MASK, 32'h10);
		wr(`GPX_OFS_SET_BIT, 56);
		chk(ext_out & ext_oe, 40'h80_0000_0000);
		wr(`GPX_OFS_EXT_HI, 32'h0f);
		chk(ext_out & ext_oe, 40'h0f_0000_0000);
		rchk(`GPX_OFS_EXT_HI, 32'h0f);
		wr(`GPX_OFS_DIR_MASK, 32'h00);
		// Input levels
		@(posedge clk_i) gen_lvl <= 8'ha5;
		ext_lvl <= 40'h00_0000_0100;
		aux_lvl <= 16'h0002;
		for (int n = 1; n <= 8; n++) begin
			wr(`GPX_OFS_IN_SEL, n);
			rchk(`GPX_OFS_IN_LEVEL, 32'h2 | ((32'ha5 >> (n - 1)) & 32'h1));
		end
		foreach (nums[k]) begin
			wr(`GPX_OFS_IN_SEL, nums[k]);
			rchk(`GPX_OFS_IN_LEVEL, exps[k]);
		end
		wr(`GPX_OFS_STEPPER, 32'h1);
		wr(`GPX_OFS_IN_SEL, 82);
		rchk(`GPX_OFS_IN_LEVEL, 32'h0);
		wr(`GPX_OFS_IN_SEL, 81);
		rchk(`GPX_OFS_IN_LEVEL, 32'h0);
		wr(`GPX_OFS_IN_SEL, 83);
		rchk(`GPX_OFS_IN_LEVEL, 32'h2);
		wr(`GPX_OFS_STEPPER, 32'h0);
		// Analog: the far side is made slow while the second half is read
		for (int i = 1; i <= 8; i++) begin
			slow <= (i > 4);
			e = (2 * i - 1) * 1250 - 10000;
			wr(`GPX_OFS_AN_SEL, i);
			for (int k = 0; k < 30; k++) begin
				rd(`GPX_OFS_AN_VAL, v);
				if (v === e) break;
			end
			chk(v, e);
			if (v !== e) finish_test();
		end
		rd(`GPX_OFS_STATUS, v);
		chk(v[`GPX_STS_ADC], 1'b1);
		// Interrupt by mask: input 2 is not enabled, input 3 is
		@(posedge clk_i) gen_lvl <= 8'hff;
		wr(`GPX_OFS_IRQ_MASK, 32'h5);
		rchk(`GPX_OFS_IRQ_MASK, 32'h5);
		@(posedge clk_i) gen_lvl <= 8'hfd;
		repeat (4) @(posedge clk_i);
		#1;
		chk(isr_active, 1'b0);
		@(posedge clk_i) gen_lvl <= 8'hf9;
		wait_for(0, 1'b1);
		rchk(`GPX_OFS_EXEC, 32'h1234_0003);
		chk(irq, 1'b0);
		@(posedge clk_i) gen_lvl <= 8'hff;
		pc <= 16'h5678;
		wr(`GPX_OFS_RET_IRQ, 32'h0);
		wait_for(2, 1'b1);
		chk(resume_addr, 16'h1234);
		chk(isr_active, 1'b0);
		// Interrupt by range, left through a stack clear
		wr(`GPX_OFS_IRQ_RANGE, 32'h0201);
		rchk(`GPX_OFS_IRQ_MASK, 32'h3);
		@(posedge clk_i) gen_lvl <= 8'hfd;
		wait_for(0, 1'b1);
		@(posedge clk_i) gen_lvl <= 8'hff;
		wr(`GPX_OFS_STK_CLR, 32'h0);
		chk({isr_active, resume}, 2'b00);
		wr(`GPX_OFS_RET_IRQ, 32'h0);
		chk(resume, 1'b0);
		rd(`GPX_OFS_EXEC, v);
		chk(v[1:0], 2'b00);
		// Status interrupt: enable, then clear
		wr(`GPX_OFS_STS_EN, 32'h1);
		wait_for(4, 1'b1);
		wr(`GPX_OFS_STS_CLR, 32'h1);
		wait_for(4, 1'b0);
		rd(`GPX_OFS_STATUS, v);
		chk(v[`GPX_STS_ISR], 1'b0);
		// Wait for high, then wait for low
		@(posedge clk_i) gen_lvl <= 8'hbf;
		wr(`GPX_OFS_WAIT, 32'h7);
		wait_for(3, 1'b1);
		repeat (3) @(posedge clk_i);
		#1;
		chk(stall, 1'b1);
		@(posedge clk_i) gen_lvl <= 8'hff;
		wait_for(3, 1'b0);
		wr(`GPX_OFS_WAIT, 32'h106);
		wait_for(3, 1'b1);
		@(posedge clk_i) gen_lvl <= 8'hdf;
		wait_for(3, 1'b0);
		// Input 9 does not exist, so no wait may be armed on it
		wr(`GPX_OFS_WAIT, 32'h9);
		chk(stall, 1'b0);
		rd(`GPX_OFS_STATUS, v);
		chk(v[`GPX_STS_WAIT], 1'b1);
		finish_test();
	end
endmodule // testbench
